// file: common/fcsp_defs.svh
/*
 * Constants for the flash command, status and protection block: register
 * offsets, field positions, reset values, command codes and timing.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef FCSP_DEFS_SVH
`define FCSP_DEFS_SVH

// Register byte offsets on the APB slave.
`define FCSP_OFF_DIVIDER    12'h000
`define FCSP_OFF_OPTION     12'h004
`define FCSP_OFF_CONFIG     12'h008
`define FCSP_OFF_PROTECT    12'h00c
`define FCSP_OFF_STATUS     12'h010
`define FCSP_OFF_COMMAND    12'h014
`define FCSP_OFF_ADDR       12'h018
`define FCSP_OFF_DATA       12'h01c
`define FCSP_OFF_BLANKIN    12'h020
`define FCSP_OFF_STOP       12'h024

// Field positions.
`define FCSP_DIVIDER_LOADED_BIT      7
`define FCSP_KEYWR_BIT      5
`define FCSP_PDIS_BIT       0
`define FCSP_CBEF_BIT       7
`define FCSP_CCF_BIT        6
`define FCSP_PVIOL_BIT      5
`define FCSP_ACCERR_BIT     4
`define FCSP_BLANK_BIT      2

// Command codes.
`define FCSP_CMD_BLANK      8'h05
`define FCSP_CMD_BYTE       8'h20
`define FCSP_CMD_BURST      8'h25
`define FCSP_CMD_PAGE       8'h40
`define FCSP_CMD_MASS       8'h41

// Key window and erased byte value.
`define FCSP_KEY_LO         16'hffb0
`define FCSP_KEY_HI         16'hffb7
`define FCSP_ERASED         8'hff
`define FCSP_SEC_UNSECURE   2'h2

// Reset values.
`define FCSP_STATUS_RST     8'hc0

// Array operation time, in ns, and the derived cycle count at 5 ns.
`define FCSP_OP_NS          40
`define FCSP_CLK_NS         5
`define FCSP_OP_CYC         ((`FCSP_OP_NS + `FCSP_CLK_NS - 1) / `FCSP_CLK_NS)

`endif

// file: common/fcsp_pkg.sv
/*
 * Types for the flash command, status and protection block.
 * Assumes fcsp_defs.svh is on the include path.
 */
`include "fcsp_defs.svh"

package fcsp_pkg;

	// Command sequence state.
	typedef enum logic [1:0] {
		FCSP_IDLE,
		FCSP_HAVE_DATA,
		FCSP_HAVE_CMD
	} fcsp_seq_e;

	// Request handed from the buffer to the array engine.
	typedef struct packed {
		logic [7:0]  code;
		logic [15:0] addr;
		logic [7:0]  data;
	} fcsp_cmd_s;

	// Status flags as kept in flip-flops.
	typedef struct packed {
		logic cbef;
		logic ccf;
		logic pviol;
		logic accerr;
		logic blank;
	} fcsp_flags_s;

endpackage

// file: hdl/fcsp_top.sv
/*
 * Flash command sequencer with status flags and block protection.
 * Holds the APB register file, the one-entry command buffer, the command
 * decoder with protection and access checks, and a timed array engine.
 * Assumes an APB master on MCLK, a synchronous active-high RESET, and an
 * outside array that reports erased state on FLASH_ALL_ERASED.
 */
//
// Behaviour
// R01 - Key writes launch commands when key-write off; code only opens a command sequence, launch needs the status write.
// R02 - Key writes compare keys when key-write on.
// R03 - Protection loaded at reset, user writes ignored.
// R04 - Protect select sets top of unprotected region.
// R05 - Refuse program or erase inside protected block.
// R06 - Protect disable bit removes all protection.
// R07 - Debug writes may change protection register.
// R08 - Buffer-empty clears on launch or burst transfer; code clears it on a good launch only and sets it on every transfer.
// R09 - Buffer-empty reads zero while buffer is full.
// R10 - Complete sets when idle, clears on launch.
// R11 - Protected launch sets violation, write one clears.
// R12 - Sequence, divider or stop errors set access error.
// R13 - Access error clears on one, zero ignored.
// R14 - Blank flag set only when array erased.
// R15 - Codes 0x05, 0x20, 0x25 recognised.
// R16 - Codes 0x40 page, 0x41 mass erase.
// R17 - Other codes raise access error.
// R18 - Blank check after mass erase is optional.
// R19 - Program and erase wait for divider write.
// R20 - Good blank check sets unsecured state code.
// R21 - Software writes data, command, then launches.
`timescale 1ns/1ps
`include "fcsp_defs.svh"

module fcsp_top #(
	parameter int          OP_CYCLES = `FCSP_OP_CYC,
	parameter logic [15:0] FLASH_BASE = 16'hf000
) (
	input  wire logic        MCLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [7:0]  STORED_PROTECTION_COPY,
	input  wire logic        DEBUG_PROT_WE,
	input  wire logic [7:0]  DEBUG_PROT_DATA,
	input  wire logic        FLASH_ALL_ERASED,
	output logic             KEY_WRITE_STB,
	output logic      [7:0]  KEY_WRITE_DATA,
	output logic      [1:0]  SECURITY_STATE_CODE,
	output logic             ARRAY_BUSY
);

	////////////////////////////////////////////////////////////////////
	// Bus decode.

	logic        wr_en;
	logic        rd_en;
	logic [7:0]  wbyte;
	logic        hit;
	logic        strap_done_reg;
	logic        div_loaded_reg;
	logic [6:0]  divider_reg;
	logic [7:0]  config_reg;
	logic [7:0]  protect_reg;
	logic [15:0] addr_reg;
	logic [7:0]  data_reg;
	logic        stop_sync1_reg;
	logic        stop_sync2_reg;
	logic        stop_req_reg;
	fcsp_pkg::fcsp_flags_s flags_reg;
	fcsp_pkg::fcsp_seq_e   seq_reg;
	fcsp_pkg::fcsp_cmd_s   buf_reg;
	fcsp_pkg::fcsp_cmd_s   run_reg;
	logic        buf_full;
	logic        running_reg;
	logic [15:0] op_cnt_reg;
	logic [7:0]  code_reg;
	logic [15:0] prot_start;
	logic        is_legal;
	logic        is_blank;
	logic        in_prot;
	logic        launch;
	logic        launch_ok;
	logic        launch_pv;
	logic        launch_ae;
	logic        seq_err;
	logic        op_done;
	logic        take;
	logic        in_key;
	logic        data_wr;

	// Every access completes in its access phase; no wait states.
	assign PREADY  = 1'b1;
	assign wr_en   = PSEL & PENABLE & PWRITE;
	assign rd_en   = PSEL & PENABLE & ~PWRITE;
	assign wbyte   = PWDATA[7:0];

	// Unmapped offsets answer with an error.
	always_comb begin
		if (PADDR == `FCSP_OFF_DIVIDER) hit = 1'b1;
		else if (PADDR == `FCSP_OFF_OPTION) hit = 1'b1;
		else if (PADDR == `FCSP_OFF_CONFIG) hit = 1'b1;
		else if (PADDR == `FCSP_OFF_PROTECT) hit = 1'b1;
		else if (PADDR == `FCSP_OFF_STATUS) hit = 1'b1;
		else if (PADDR == `FCSP_OFF_COMMAND) hit = 1'b1;
		else if (PADDR == `FCSP_OFF_ADDR) hit = 1'b1;
		else if (PADDR == `FCSP_OFF_DATA) hit = 1'b1;
		else if (PADDR == `FCSP_OFF_BLANKIN) hit = 1'b1;
		else if (PADDR == `FCSP_OFF_STOP) hit = 1'b1;
		else hit = 1'b0;
	end
	assign PSLVERR = PSEL & PENABLE & ~hit;

	////////////////////////////////////////////////////////////////////
	// Divider and configuration.

	// The first divider write after reset enables program and erase.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			div_loaded_reg <= 1'b0;
			divider_reg    <= 7'h00;
		end else if (wr_en && PADDR == `FCSP_OFF_DIVIDER) begin
			div_loaded_reg <= 1'b1; // R19
			divider_reg    <= wbyte[6:0];
		end
	end

	// Only the key-write enable is writable here.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			config_reg <= 8'h00;
		end else if (wr_en && PADDR == `FCSP_OFF_CONFIG) begin
			config_reg <= wbyte & (8'h01 << `FCSP_KEYWR_BIT);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Protection register.

	// The stored copy is caught by a clocked load while reset is held and on the first edge after release,
	// so the reset branch itself sees only constants elsewhere.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			strap_done_reg <= 1'b0;
		end else begin
			strap_done_reg <= 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET || !strap_done_reg) begin
			protect_reg <= STORED_PROTECTION_COPY; // R03
		end else if (DEBUG_PROT_WE) begin
			protect_reg <= DEBUG_PROT_DATA; // R07
		end
	end

	// Protected block lies above the last unprotected address; each select
	// step is 512 bytes. Comparing with that last address, not one past it,
	// keeps an all-ones select from wrapping round and protecting it all.
	assign prot_start = {protect_reg[7:1], 9'h1ff}; // R04
	assign in_prot    = ~protect_reg[`FCSP_PDIS_BIT] && // R06
	                    (code_reg == `FCSP_CMD_MASS ||
	                     addr_reg > prot_start);

	////////////////////////////////////////////////////////////////////
	// Stop request, from an APB write to the stop register, through a synchroniser.

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			stop_sync1_reg <= 1'b0;
			stop_sync2_reg <= 1'b0;
			stop_req_reg   <= 1'b0;
		end else begin
			stop_sync1_reg <= stop_req_reg;
			stop_sync2_reg <= stop_sync1_reg;
			stop_req_reg   <= wr_en && PADDR == `FCSP_OFF_STOP;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Command sequence: data write, code write, launch.

	assign in_key  = addr_reg >= `FCSP_KEY_LO && addr_reg <= `FCSP_KEY_HI;
	assign data_wr = wr_en && PADDR == `FCSP_OFF_DATA;
	assign launch  = wr_en && PADDR == `FCSP_OFF_STATUS &&
	                 wbyte[`FCSP_CBEF_BIT] && flags_reg.cbef;
	assign is_legal = code_reg == `FCSP_CMD_BLANK || // R15
	                  code_reg == `FCSP_CMD_BYTE ||
	                  code_reg == `FCSP_CMD_BURST ||
	                  code_reg == `FCSP_CMD_PAGE || // R16
	                  code_reg == `FCSP_CMD_MASS;
	assign is_blank  = code_reg == `FCSP_CMD_BLANK;
	assign seq_err   = seq_reg != fcsp_pkg::FCSP_HAVE_CMD;
	assign launch_ae = launch && (seq_err || !is_legal || // R17
	                   (!is_blank && !div_loaded_reg)); // R12
	assign launch_pv = launch && !launch_ae && !is_blank && in_prot; // R05
	assign launch_ok = launch && !launch_ae && !launch_pv;

	// Key writes steer to the comparator when key-write is enabled;
	// otherwise a data write opens a command sequence.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			addr_reg       <= 16'h0000;
			KEY_WRITE_STB  <= 1'b0;
			KEY_WRITE_DATA <= 8'h00;
		end else begin
			KEY_WRITE_STB <= 1'b0;
			if (wr_en && PADDR == `FCSP_OFF_ADDR) begin
				addr_reg <= PWDATA[15:0];
			end
			if (data_wr && in_key && config_reg[`FCSP_KEYWR_BIT]) begin
				KEY_WRITE_STB  <= 1'b1; // R02
				KEY_WRITE_DATA <= wbyte;
			end
		end
	end

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			seq_reg  <= fcsp_pkg::FCSP_IDLE;
			data_reg <= 8'h00;
			code_reg <= 8'h00;
		end else begin
			case (seq_reg)
			fcsp_pkg::FCSP_IDLE: begin
				if (data_wr && flags_reg.cbef &&
				    !(in_key && config_reg[`FCSP_KEYWR_BIT])) begin
					data_reg <= wbyte; // R01
					seq_reg  <= fcsp_pkg::FCSP_HAVE_DATA;
				end
			end
			fcsp_pkg::FCSP_HAVE_DATA: begin
				if (wr_en && PADDR == `FCSP_OFF_COMMAND) begin
					code_reg <= wbyte;
					seq_reg  <= fcsp_pkg::FCSP_HAVE_CMD;
				end else if (launch) begin
					seq_reg <= fcsp_pkg::FCSP_IDLE;
				end
			end
			default: begin
				if (launch) begin
					seq_reg <= fcsp_pkg::FCSP_IDLE;
				end
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// One-entry command buffer and timed array engine.

	assign buf_full = ~flags_reg.cbef;
	assign op_done  = running_reg && op_cnt_reg == 16'h0000;
	// The engine takes the buffer when idle, or straight on for a burst;
	// buffer-empty follows the same term, so a queued burst is lost only if a stop lands in that cycle.
	assign take     = buf_full && (!running_reg ||
	                  (op_done && buf_reg.code == `FCSP_CMD_BURST));

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			buf_reg     <= '0;
			run_reg     <= '0;
			running_reg <= 1'b0;
			op_cnt_reg  <= 16'h0000;
		end else begin
			if (launch_ok) begin
				buf_reg <= '{code: code_reg, addr: addr_reg, data: data_reg};
			end
			if (stop_sync2_reg && running_reg) begin
				running_reg <= 1'b0;
			end else if (take) begin
				run_reg     <= buf_reg;
				running_reg <= 1'b1;
				op_cnt_reg  <= OP_CYCLES[15:0] - 16'h0001;
			end else if (op_done) begin
				running_reg <= 1'b0;
			end else if (running_reg) begin
				op_cnt_reg <= op_cnt_reg - 16'h0001;
			end
		end
	end
	assign ARRAY_BUSY = running_reg;

	////////////////////////////////////////////////////////////////////
	// Status flags. Hardware sets win over software clears.

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			flags_reg <= '{cbef: 1'b1, ccf: 1'b1, pviol: 1'b0,
			               accerr: 1'b0, blank: 1'b0};
		end else begin
			// Buffer fills on a good launch, empties when the engine takes it.
			if (launch_ok) begin
				flags_reg.cbef <= 1'b0; // R08
			end else if (launch) begin
				flags_reg.cbef <= 1'b1;
			end else if (take) begin
				flags_reg.cbef <= 1'b1; // R09
			end
			// Complete only once buffer and engine are both idle.
			if (launch_ok) begin
				flags_reg.ccf <= 1'b0; // R10
			end else begin
				flags_reg.ccf <= flags_reg.cbef && !running_reg;
			end
			if (launch_pv) begin
				flags_reg.pviol <= 1'b1; // R11
			end else if (wr_en && PADDR == `FCSP_OFF_STATUS &&
			             wbyte[`FCSP_PVIOL_BIT]) begin
				flags_reg.pviol <= 1'b0;
			end
			if (launch_ae || (stop_sync2_reg && running_reg)) begin
				flags_reg.accerr <= 1'b1; // R12
			end else if (wr_en && PADDR == `FCSP_OFF_STATUS &&
			             wbyte[`FCSP_ACCERR_BIT]) begin
				flags_reg.accerr <= 1'b0; // R13
			end
			if (op_done && run_reg.code == `FCSP_CMD_BLANK) begin
				flags_reg.blank <= FLASH_ALL_ERASED; // R14
			end else if (launch_ok) begin
				flags_reg.blank <= 1'b0;
			end
		end
	end

	// A good blank check unsecures the part until the next reset.
	always_ff @(posedge MCLK) begin
		if (RESET) begin
			SECURITY_STATE_CODE <= 2'h0;
		end else if (op_done && run_reg.code == `FCSP_CMD_BLANK &&
		             FLASH_ALL_ERASED) begin
			SECURITY_STATE_CODE <= `FCSP_SEC_UNSECURE; // R20
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read data, registered in the setup phase.

	always_ff @(posedge MCLK) begin
		if (RESET) begin
			PRDATA <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			if (PADDR == `FCSP_OFF_DIVIDER) begin
				PRDATA <= {24'h0, div_loaded_reg, divider_reg};
			end else if (PADDR == `FCSP_OFF_CONFIG) begin
				PRDATA <= {24'h0, config_reg};
			end else if (PADDR == `FCSP_OFF_PROTECT) begin
				PRDATA <= {24'h0, protect_reg};
			end else if (PADDR == `FCSP_OFF_STATUS) begin
				PRDATA <= {24'h0, flags_reg.cbef, flags_reg.ccf,
				           flags_reg.pviol, flags_reg.accerr, 1'b0,
				           flags_reg.blank, 2'h0};
			end else if (PADDR == `FCSP_OFF_COMMAND) begin
				PRDATA <= {24'h0, code_reg};
			end else if (PADDR == `FCSP_OFF_ADDR) begin
				PRDATA <= {16'h0, addr_reg};
			end else if (PADDR == `FCSP_OFF_DATA) begin
				PRDATA <= {24'h0, data_reg};
			end else if (PADDR == `FCSP_OFF_OPTION) begin
				PRDATA <= {30'h0, SECURITY_STATE_CODE};
			end else begin
				PRDATA <= 32'h0000_0000;
			end
		end
	end

endmodule

// file: bench/fcsp_top_properties.sv
/*
 * Port-level checker for the flash sequencer top, bound into fcsp_top.
 * Assumes one MCLK domain with synchronous active-high RESET.
 */
`timescale 1ns/1ps
module fcsp_top_properties #(
	parameter int OP_CYCLES = 8
) (
	input wire logic        MCLK,
	input wire logic        RESET,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        KEY_WRITE_STB,
	input wire logic [7:0]  KEY_WRITE_DATA,
	input wire logic [1:0]  SECURITY_STATE_CODE,
	input wire logic        ARRAY_BUSY
);
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (RESET);
	logic [7:0] busy_run_reg;
	logic       pend_reg;
	logic       launch_wr;
	// A launch seen while busy may queue a burst behind the running one.
	assign launch_wr = PSEL && PENABLE && PWRITE && PADDR == 12'h010 &&
		PWDATA[7];
	// Cycles into the current operation; a stuck engine shows as overrun.
	always_ff @(posedge MCLK) begin
		if (RESET || !ARRAY_BUSY || busy_run_reg == 8'(OP_CYCLES - 1))
			busy_run_reg <= 8'h00;
		else
			busy_run_reg <= busy_run_reg + 8'h01;
	end
	// Marks a queued command so a chained operation is not taken as overrun.
	always_ff @(posedge MCLK) begin
		if (RESET || !ARRAY_BUSY)
			pend_reg <= 1'b0;
		else if (launch_wr)
			pend_reg <= 1'b1;
		else if (busy_run_reg == 8'(OP_CYCLES - 1))
			pend_reg <= 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	property p_ready; PSEL |-> PREADY; endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_err_phase; PSLVERR |-> PSEL && PENABLE; endproperty
	a_err_phase: assert property (p_err_phase)
		else $error("error outside access");
	property p_err_map; PSEL && PENABLE && PADDR > 12'h024 |-> PSLVERR;
	endproperty
	a_err_map: assert property (p_err_map)
		else $error("unmapped access not refused");
	property p_busy_len; ARRAY_BUSY && !pend_reg &&
		busy_run_reg == 8'(OP_CYCLES - 1) |=> !ARRAY_BUSY; endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("array busy too long");
	property p_sec_legal;
		SECURITY_STATE_CODE == 2'h0 || SECURITY_STATE_CODE == 2'h2;
	endproperty
	a_sec_legal: assert property (p_sec_legal)
		else $error("bad security code");
	property p_sec_hold; SECURITY_STATE_CODE == 2'h2 |=>
		SECURITY_STATE_CODE == 2'h2; endproperty
	a_sec_hold: assert property (p_sec_hold)
		else $error("security code lost");
	property p_key_cause; KEY_WRITE_STB |->
		$past(PSEL && PENABLE && PWRITE && PADDR == 12'h01c) &&
		KEY_WRITE_DATA == $past(PWDATA[7:0]); endproperty
	a_key_cause: assert property (p_key_cause)
		else $error("key write without data write");
	property p_key_single; KEY_WRITE_STB |=> !KEY_WRITE_STB; endproperty
	a_key_single: assert property (p_key_single)
		else $error("key strobe too long");
endmodule
bind fcsp_top fcsp_top_properties #(.OP_CYCLES(OP_CYCLES)) i_props (
	.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
	.PSLVERR(PSLVERR), .KEY_WRITE_STB(KEY_WRITE_STB),
	.KEY_WRITE_DATA(KEY_WRITE_DATA),
	.SECURITY_STATE_CODE(SECURITY_STATE_CODE), .ARRAY_BUSY(ARRAY_BUSY));

// file: bench/fcsp_top_bench.sv
/*
 * Self-checking bench for the flash sequencer top over APB.
 * Assumes the defs header on the include path; OP_CYCLES is raised so a
 * burst can be queued behind a running one.
 */
`timescale 1ns/1ps
`include "fcsp_defs.svh"
module fcsp_top_bench;
	logic        MCLK, RESET, PSEL, PENABLE, PWRITE, DEBUG_PROT_WE;
	logic        FLASH_ALL_ERASED, PREADY, PSLVERR, KEY_WRITE_STB;
	logic        ARRAY_BUSY;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, q;
	logic [7:0]  STORED_PROTECTION_COPY, DEBUG_PROT_DATA, KEY_WRITE_DATA;
	logic [1:0]  SECURITY_STATE_CODE;
	int          failures, checked, keys;
	fcsp_top #(.OP_CYCLES(24)) i_fcsp_top (.MCLK(MCLK), .RESET(RESET),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .STORED_PROTECTION_COPY(STORED_PROTECTION_COPY),
		.DEBUG_PROT_WE(DEBUG_PROT_WE), .DEBUG_PROT_DATA(DEBUG_PROT_DATA),
		.FLASH_ALL_ERASED(FLASH_ALL_ERASED), .KEY_WRITE_STB(KEY_WRITE_STB),
		.KEY_WRITE_DATA(KEY_WRITE_DATA), .ARRAY_BUSY(ARRAY_BUSY),
		.SECURITY_STATE_CODE(SECURITY_STATE_CODE));
	// Clock at 200 MHz.
	initial begin
		MCLK = 1'b0;
		forever #2.5 MCLK = ~MCLK;
	end
	// Key strobes are counted so silent or doubled strobes are both seen.
	always @(posedge MCLK) begin
		if (KEY_WRITE_STB === 1'b1)
			keys++;
	end
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// One APB transfer; the request holds until PREADY is seen high.
	task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		@(posedge MCLK);
		while (PREADY !== 1'b1)
			@(posedge MCLK);
		q = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		xf(1'b1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] exp);
		xf(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	// Full sequence: address, data, code, then launch.
	task cmd(input logic [15:0] a, input logic [7:0] c);
		wr(`FCSP_OFF_ADDR, {16'h0, a});
		wr(`FCSP_OFF_DATA, 32'h3c);
		wr(`FCSP_OFF_COMMAND, {24'h0, c});
		wr(`FCSP_OFF_STATUS, 32'h80);
	endtask
	task done;
		for (int i = 0; i < 40 && q[6] !== 1'b1; i++)
			xf(1'b0, `FCSP_OFF_STATUS, 32'h0);
	endtask
	task run(input logic [15:0] a, input logic [7:0] c, input logic [7:0] e);
		cmd(a, c);
		q = 32'h0;
		done;
		rdc(`FCSP_OFF_STATUS, {24'h0, e});
		wr(`FCSP_OFF_STATUS, 32'h30);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_reset;
		rdc(`FCSP_OFF_PROTECT, 32'hf8);
		rdc(`FCSP_OFF_STATUS, 32'hc0);
		wr(`FCSP_OFF_PROTECT, 32'h01);
		rdc(`FCSP_OFF_PROTECT, 32'hf8);
		rdc(`FCSP_OFF_DIVIDER, 32'h0);
		wr(12'h040, 32'hff);
		rdc(12'h040, 32'h0);
		run(16'hf000, `FCSP_CMD_BYTE, 8'hd0);
		wr(`FCSP_OFF_STATUS, 32'h10);
		rdc(`FCSP_OFF_STATUS, 32'hc0);
		wr(`FCSP_OFF_DIVIDER, 32'h04);
		rdc(`FCSP_OFF_DIVIDER, 32'h84);
		wr(`FCSP_OFF_STATUS, 32'h80);
		wr(`FCSP_OFF_STATUS, 32'h40);
		rdc(`FCSP_OFF_STATUS, 32'hd0);
		wr(`FCSP_OFF_STATUS, 32'h30);
		$display("test reset done");
	endtask
	task t_protect;
		cmd(16'hf000, `FCSP_CMD_BYTE);
		rdc(`FCSP_OFF_STATUS, 32'h80);
		q = 32'h0;
		done;
		rdc(`FCSP_OFF_STATUS, 32'hc0);
		run(16'hfa00, `FCSP_CMD_BYTE, 8'he0);
		rdc(`FCSP_OFF_STATUS, 32'hc0);
		run(16'hf9ff, `FCSP_CMD_BYTE, 8'hc0);
		run(16'h0000, `FCSP_CMD_MASS, 8'he0);
		@(posedge MCLK);
		DEBUG_PROT_WE <= 1'b1;
		DEBUG_PROT_DATA <= 8'hf9;
		@(posedge MCLK);
		DEBUG_PROT_WE <= 1'b0;
		rdc(`FCSP_OFF_PROTECT, 32'hf9);
		run(16'hfc00, `FCSP_CMD_PAGE, 8'hc0);
		run(16'h0000, `FCSP_CMD_MASS, 8'hc0);
		run(16'hf000, `FCSP_CMD_BYTE, 8'hc0);
		$display("test protect done");
	endtask
	task t_blank;
		run(16'hf000, `FCSP_CMD_BLANK, 8'hc0);
		chk(SECURITY_STATE_CODE, 2'h0);
		FLASH_ALL_ERASED <= 1'b1;
		run(16'hf000, `FCSP_CMD_BLANK, 8'hc4);
		chk(SECURITY_STATE_CODE, 2'h2);
		rdc(`FCSP_OFF_OPTION, 32'h2);
		run(16'hf000, `FCSP_CMD_BYTE, 8'hc0);
		$display("test blank done");
	endtask
	task t_misc;
		logic [7:0] bad [4];
		bad = '{8'h00, 8'h33, 8'h42, 8'hff};
		foreach (bad[i])
			run(16'hf000, bad[i], 8'hd0);
		wr(`FCSP_OFF_CONFIG, 32'h20);
		keys = 0;
		wr(`FCSP_OFF_ADDR, 32'hffb0);
		wr(`FCSP_OFF_DATA, 32'h5a);
		repeat (2) @(posedge MCLK);
		chk(keys, 1);
		chk(KEY_WRITE_DATA, 8'h5a);
		wr(`FCSP_OFF_CONFIG, 32'h00);
		run(16'hffb7, `FCSP_CMD_BYTE, 8'hc0);
		chk(keys, 1);
		cmd(16'hf000, `FCSP_CMD_BURST);
		cmd(16'hf001, `FCSP_CMD_BURST);
		rdc(`FCSP_OFF_STATUS, 32'h00);
		q = 32'h0;
		done;
		rdc(`FCSP_OFF_STATUS, 32'hc0);
		cmd(16'hf000, `FCSP_CMD_BYTE);
		wr(`FCSP_OFF_STOP, 32'h01);
		repeat (4) @(posedge MCLK);
		rdc(`FCSP_OFF_STATUS, 32'hd0);
		$display("test misc done");
	endtask
	// Watchdog sized well beyond the few thousand ns the tests need.
	initial begin
		#200000;
		failures++;
		summarize();
	end
	// Main sequence.
	initial begin
		{PSEL, PENABLE, PWRITE, DEBUG_PROT_WE, FLASH_ALL_ERASED} = 5'h00;
		{PADDR, PWDATA, DEBUG_PROT_DATA} = 52'h0;
		STORED_PROTECTION_COPY = 8'hf8;
		{failures, checked, keys} = 96'h0;
		RESET = 1'b1;
		repeat (2) @(posedge MCLK);
		RESET <= 1'b0;
		t_reset();
		t_protect();
		t_blank();
		t_misc();
		summarize();
	end
endmodule
